// ---- logic/efs_pkg.sv ----
// Shared constants and types of the fault supervisor.
// Assumes a single 25 MHz clock; times are given in microseconds and scaled in the supervisor.
package efs_pkg;

    // ************************************************************
    // Clock and default timing
    // ************************************************************
    localparam int CLK_MHZ          = 25;       // 40 ns period
    localparam int PGA_US_DEF       = 500;      // Power-good assert deglitch
    localparam int PGD_US_DEF       = 20;       // Power-good de-assert deglitch
    localparam int QOD_US_DEF       = 1000;     // Discharge hold time
    localparam int SU_US_DEF        = 20000;    // Start-up timeout
    localparam int SPF_US_DEF       = 5000;     // Backup blanking timer
    localparam int RST_US_DEF       = 100000;   // Auto-retry delay
    localparam int GS_US            = 10;       // Longest G-S fault response
    localparam int CURRENT_MONITOR_PIN_SPF_US      = 50;       // Longest shorted-monitor response
    localparam int TMR_W            = 24;
    localparam logic [2:0] SWITCH_ENABLE_LINE_SETTLE = 3'h7;  // Cycles before sensing the line

    // ************************************************************
    // Synchronised flag positions
    // ************************************************************
    localparam int IN_W             = 16;
    localparam int I_TEMP_HOT       = 0;
    localparam int I_TEMP_COOL      = 1;
    localparam int I_EN_ON          = 2;
    localparam int I_EN_ABOVE_SD    = 3;
    localparam int I_SUPPLY_OK      = 4;
    localparam int I_UV_OV          = 5;
    localparam int I_OC_PRIMARY     = 6;
    localparam int I_OC_BACKUP      = 7;
    localparam int I_FAST_TRIP      = 8;
    localparam int I_BLANK_EXPIRED  = 9;
    localparam int I_BLANK_STUCK    = 10;
    localparam int I_GATE_OVERDRIVE = 11;
    localparam int I_GATE_NEAR_VIN  = 12;
    localparam int I_VDS_LOW        = 13;
    localparam int I_VOUT_BELOW_FB  = 14;
    localparam int I_SWITCH_ENABLE_LINE_SENSE     = 15;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int AW               = 4;
    localparam int DW               = 8;
    localparam logic [AW-1:0] ADDR_CTRL   = 4'h0;
    localparam logic [AW-1:0] ADDR_STATUS = 4'h4;
    localparam logic [AW-1:0] ADDR_CAUSE  = 4'h8;
    localparam int CTRL_AUTO_RETRY  = 0;
    localparam int ST_FLT           = 0;
    localparam int ST_GATE          = 1;
    localparam int ST_DISCH         = 2;
    localparam int ST_PG            = 3;
    localparam int ST_STATE_LSB     = 4;
    localparam int C_THERM          = 0;
    localparam int C_BREAKER        = 1;
    localparam int C_FAST_TRIP      = 2;
    localparam int C_SPF_CURRENT_MONITOR_PIN       = 3;
    localparam int C_SPF_TIMER      = 4;
    localparam int C_GS             = 5;
    localparam int C_GD             = 6;
    localparam int C_EXT            = 7;
    localparam logic [DW-1:0] RETRYABLE = 8'h07;

    typedef enum logic [3:0] {
        S_OFF,
        S_DS_CHECK,
        S_DS_FAULT,
        S_INRUSH,
        S_STEADY,
        S_LATCHED,
        S_COOL,
        S_RETRY
    } efs_state_t;

endpackage

// ---- logic/efs_sync.sv ----
// Three-stage synchroniser for a vector of comparator flags.
// Assumes every input bit is asynchronous to clk; output changes once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module efs_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Flags
    input  wire logic [W-1:0] d_in,
    output var  logic [W-1:0] q_out
);

    // ************************************************************
    // Per-bit stages
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic s1_r;
            logic s2_r;
            logic s3_r;
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                end else begin
                    s1_r <= d_in[g];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                end
            end
            // Only stages two and three are compared; stage one may be metastable
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    q_out[g] <= 1'b0;
                end else if (s2_r == s3_r) begin
                    q_out[g] <= s3_r;
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// ---- logic/efs_supervisor.sv ----
// Fault supervisor of a hotswap protection switch: state machine, timers, indicators, registers.
// Assumes comparator flags arrive asynchronously from analog sensing and MCLK runs at 25 MHz.
`timescale 1ns/1ps
`default_nettype none

module efs_supervisor
    import efs_pkg::*;
#(
    parameter int         PGA_US     = PGA_US_DEF,
    parameter int         PGD_US     = PGD_US_DEF,
    parameter int         QOD_US     = QOD_US_DEF,
    parameter int         SU_US      = SU_US_DEF,
    parameter int         SPF_US     = SPF_US_DEF,
    parameter int         RST_US     = RST_US_DEF,
    parameter logic       AUTO_RETRY = 1'b0
) (
    // Clock and reset
    input  wire logic          MCLK,
    input  wire logic          RST,
    // Thermal comparators
    input  wire logic          TEMP_HOT,
    input  wire logic          TEMP_COOL,
    // Enable and supply comparators
    input  wire logic          EN_ON,
    input  wire logic          EN_ABOVE_SD,
    input  wire logic          SUPPLY_OK,
    input  wire logic          UV_OV,
    // Current comparators
    input  wire logic          OC_PRIMARY,
    input  wire logic          OC_BACKUP,
    input  wire logic          FAST_TRIP,
    input  wire logic          BLANK_EXPIRED,
    input  wire logic          BLANK_STUCK,
    // FET health comparators
    input  wire logic          GATE_OVERDRIVE,
    input  wire logic          GATE_NEAR_VIN,
    input  wire logic          VDS_LOW,
    input  wire logic          VOUT_BELOW_FB,
    // Gate driver and discharge
    output var  logic          GATE_DRIVE_ON,
    output var  logic          OUTPUT_DISCHARGE,
    // Switch enable line, open drain
    input  wire logic          SWITCH_ENABLE_LINE_I,
    output var  logic          SWITCH_ENABLE_LINE_O,
    output var  logic          SWITCH_ENABLE_LINE_OE,
    // Fault indicator, open drain, active low
    output var  logic          FAULT_INDICATOR_N_O,
    output var  logic          FAULT_INDICATOR_N_OE,
    // Power good
    output var  logic          POWER_GOOD_OUT,
    // Register port
    input  wire logic [AW-1:0] BUS_ADDR,
    input  wire logic [DW-1:0] BUS_WDATA,
    input  wire logic          BUS_WR,
    input  wire logic          BUS_RD,
    output var  logic [DW-1:0] BUS_RDATA
);

    // ************************************************************
    // Timing counts
    // ************************************************************
    localparam int PGA_CYC = (PGA_US * CLK_MHZ < 1) ? 1 : PGA_US * CLK_MHZ;
    localparam int PGD_CYC = (PGD_US * CLK_MHZ < 1) ? 1 : PGD_US * CLK_MHZ;
    localparam int QOD_CYC = (QOD_US * CLK_MHZ < 1) ? 1 : QOD_US * CLK_MHZ;
    localparam int SU_CYC  = (SU_US * CLK_MHZ < 1) ? 1 : SU_US * CLK_MHZ;
    localparam int SPF_CYC = (SPF_US * CLK_MHZ < 1) ? 1 : SPF_US * CLK_MHZ;
    localparam int RST_CYC = (RST_US * CLK_MHZ < 1) ? 1 : RST_US * CLK_MHZ;
    localparam logic [TMR_W-1:0] PGA_LIM = TMR_W'(PGA_CYC - 1);
    localparam logic [TMR_W-1:0] PGD_LIM = TMR_W'(PGD_CYC - 1);
    localparam logic [TMR_W-1:0] QOD_LIM = TMR_W'(QOD_CYC - 1);
    localparam logic [TMR_W-1:0] SU_LIM  = TMR_W'(SU_CYC - 1);
    localparam logic [TMR_W-1:0] SPF_LIM = TMR_W'(SPF_CYC - 1);
    localparam logic [TMR_W-1:0] RST_LIM = TMR_W'(RST_CYC - 1);

    // ************************************************************
    // Input synchronisation
    // ************************************************************
    logic [IN_W-1:0] raw;
    logic [IN_W-1:0] s;

    assign raw = {SWITCH_ENABLE_LINE_I, VOUT_BELOW_FB, VDS_LOW, GATE_NEAR_VIN, GATE_OVERDRIVE,
                  BLANK_STUCK, BLANK_EXPIRED, FAST_TRIP, OC_BACKUP, OC_PRIMARY,
                  UV_OV, SUPPLY_OK, EN_ABOVE_SD, EN_ON, TEMP_COOL, TEMP_HOT};

    efs_sync #(
        .W     (IN_W)
    ) u_sync (
        .clk   (MCLK),
        .rst   (RST),
        .d_in  (raw),
        .q_out (s)
    );

    // ************************************************************
    // State and storage
    // ************************************************************
    efs_state_t        state_r;
    efs_state_t        state_nxt;
    logic [TMR_W-1:0]  tmr_r;
    logic [TMR_W-1:0]  bkp_r;
    logic [TMR_W-1:0]  qod_cnt_r;
    logic [TMR_W-1:0]  pg_cnt_r;
    logic [2:0]        switch_enable_line_age_r;
    logic [DW-1:0]     cause_r;
    logic [DW-1:0]     cause_set;
    logic              auto_retry_r;
    logic              gate_r;
    logic              dis_r;
    logic              qod_r;
    logic              flt_r;
    logic              pg_r;
    logic              clear_latch;
    logic              lockout;
    logic              pg_want;
    logic              qod_band;

    assign clear_latch = !s[I_EN_ABOVE_SD] || !s[I_SUPPLY_OK];
    assign lockout     = !s[I_EN_ON] || s[I_UV_OV];
    assign qod_band    = s[I_EN_ABOVE_SD] && !s[I_EN_ON];

    // ************************************************************
    // Fault detection and next state
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        cause_set = '0;
        // Gate commanded off yet near the input
        if (!gate_r && s[I_GATE_NEAR_VIN]) begin
            cause_set[C_GD] = 1'b1;
        end
        if (gate_r || state_r == S_DS_CHECK) begin
            cause_set[C_THERM] = s[I_TEMP_HOT];
        end
        // Line sensed low while we release it and UV_OV is not flagged
        if (gate_r && switch_enable_line_age_r == SWITCH_ENABLE_LINE_SETTLE && !s[I_SWITCH_ENABLE_LINE_SENSE] && !s[I_UV_OV]) begin
            cause_set[C_EXT] = 1'b1;
        end
        if (state_r == S_INRUSH && tmr_r >= SU_LIM && !s[I_GATE_OVERDRIVE]) begin
            cause_set[C_GS] = 1'b1;
        end
        if (state_r == S_STEADY) begin
            cause_set[C_FAST_TRIP] = s[I_FAST_TRIP];
            // An open monitor pin reads as overcurrent; a dead timer pin reads as expired
            cause_set[C_BREAKER]   = s[I_OC_PRIMARY] && s[I_BLANK_EXPIRED];
            cause_set[C_SPF_CURRENT_MONITOR_PIN]  = s[I_OC_BACKUP] && !s[I_OC_PRIMARY] && !s[I_FAST_TRIP];
            cause_set[C_SPF_TIMER] = bkp_r >= SPF_LIM;
            cause_set[C_GS]        = !s[I_GATE_OVERDRIVE];
        end
        unique case (state_r)
            S_OFF: begin
                if (!clear_latch && !lockout) begin
                    state_nxt = S_DS_CHECK;
                end
            end
            S_DS_CHECK: begin
                if (!s[I_VDS_LOW] || s[I_VOUT_BELOW_FB]) begin
                    state_nxt = S_INRUSH;
                end else if (tmr_r >= SU_LIM) begin
                    state_nxt = S_DS_FAULT;
                end
            end
            S_DS_FAULT: begin
                // Not latched: any lockout lets the start-up run again
                if (lockout) begin
                    state_nxt = S_OFF;
                end
            end
            S_INRUSH: begin
                if (s[I_GATE_OVERDRIVE]) begin
                    state_nxt = S_STEADY;
                end
            end
            S_STEADY: begin
                state_nxt = S_STEADY;
            end
            S_LATCHED: begin
                state_nxt = S_LATCHED;
            end
            S_COOL: begin
                if (s[I_TEMP_COOL]) begin
                    state_nxt = S_RETRY;
                end
            end
            S_RETRY: begin
                if (tmr_r >= RST_LIM) begin
                    state_nxt = S_OFF;
                end
            end
        endcase
        if ((state_r == S_DS_CHECK || state_r == S_INRUSH || state_r == S_STEADY) && lockout) begin
            state_nxt = S_OFF;
        end
        // A new fault wins over a clear arriving in the same cycle
        if (|cause_set) begin
            if (auto_retry_r && ((cause_set & ~RETRYABLE) == '0)) begin
                state_nxt = cause_set[C_THERM] ? S_COOL : S_RETRY;
            end else begin
                state_nxt = S_LATCHED;
            end
        end else if (clear_latch) begin
            state_nxt = S_OFF;
        end
    end

    // ************************************************************
    // State register and sequence timer
    // ************************************************************
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state_r <= S_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Retry and start-up share one timer; a clear restarts it via the state change
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            tmr_r <= '0;
        end else if (state_nxt != state_r) begin
            tmr_r <= '0;
        end else if (tmr_r != {TMR_W{1'b1}}) begin
            tmr_r <= tmr_r + 1'b1;
        end
    end

    // Backup blanking timer for a timer pin that cannot discharge
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            bkp_r <= '0;
        end else if (state_r == S_STEADY && s[I_BLANK_STUCK] && (s[I_OC_PRIMARY] || s[I_OC_BACKUP])) begin
            if (bkp_r < SPF_LIM) begin
                bkp_r <= bkp_r + 1'b1;
            end
        end else begin
            bkp_r <= '0;
        end
    end

    // ************************************************************
    // Gate drive and enable line
    // ************************************************************
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            gate_r <= 1'b0;
        end else begin
            gate_r <= (state_nxt == S_INRUSH) || (state_nxt == S_STEADY);
        end
    end

    // Sensing is blanked until the released line has passed the synchroniser
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            switch_enable_line_age_r <= '0;
        end else if (!gate_r) begin
            switch_enable_line_age_r <= '0;
        end else if (switch_enable_line_age_r != SWITCH_ENABLE_LINE_SETTLE) begin
            switch_enable_line_age_r <= switch_enable_line_age_r + 1'b1;
        end
    end

    assign SWITCH_ENABLE_LINE_O  = 1'b0;
    assign SWITCH_ENABLE_LINE_OE = !gate_r;
    assign GATE_DRIVE_ON         = gate_r;

    // ************************************************************
    // Output discharge
    // ************************************************************
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            qod_cnt_r <= '0;
        end else if (state_r == S_OFF && qod_band) begin
            if (qod_cnt_r < QOD_LIM) begin
                qod_cnt_r <= qod_cnt_r + 1'b1;
            end
        end else begin
            qod_cnt_r <= '0;
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            qod_r <= 1'b0;
        end else if (s[I_VOUT_BELOW_FB] || (|cause_set) || !qod_band || state_r != S_OFF) begin
            qod_r <= 1'b0;
        end else if (qod_cnt_r >= QOD_LIM) begin
            qod_r <= 1'b1;
        end
    end

    // Thermal threshold overrides both discharge requests
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            dis_r <= 1'b0;
        end else begin
            dis_r <= (qod_r || (state_r == S_DS_CHECK && state_nxt == S_DS_CHECK && s[I_VDS_LOW]))
                     && !s[I_TEMP_HOT] && !(|cause_set);
        end
    end

    assign OUTPUT_DISCHARGE = dis_r;

    // ************************************************************
    // Fault indicator
    // ************************************************************
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            flt_r <= 1'b0;
        end else begin
            flt_r <= (state_nxt == S_LATCHED) || (state_nxt == S_COOL) ||
                     (state_nxt == S_RETRY) || (state_nxt == S_DS_FAULT);
        end
    end

    assign FAULT_INDICATOR_N_O  = 1'b0;
    assign FAULT_INDICATOR_N_OE = flt_r;

    // Causes stay until a clear; a set in the same cycle survives it
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            cause_r <= '0;
        end else begin
            cause_r <= (clear_latch ? '0 : cause_r) | cause_set;
        end
    end

    // ************************************************************
    // Power good with deglitch
    // ************************************************************
    assign pg_want = (state_r == S_STEADY) && gate_r;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            pg_r     <= 1'b0;
            pg_cnt_r <= '0;
        end else if (pg_want == pg_r) begin
            pg_cnt_r <= '0;
        end else if (pg_cnt_r >= (pg_want ? PGA_LIM : PGD_LIM)) begin
            pg_r     <= pg_want;
            pg_cnt_r <= '0;
        end else begin
            pg_cnt_r <= pg_cnt_r + 1'b1;
        end
    end

    assign POWER_GOOD_OUT = pg_r;

    // ************************************************************
    // Register port
    // ************************************************************
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            auto_retry_r <= AUTO_RETRY;
        end else if (BUS_WR && BUS_ADDR == ADDR_CTRL) begin
            auto_retry_r <= BUS_WDATA[CTRL_AUTO_RETRY];
        end
    end

    // Unmapped addresses and idle cycles read as zero
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            BUS_RDATA <= '0;
        end else if (BUS_RD && BUS_ADDR == ADDR_CTRL) begin
            BUS_RDATA <= {{(DW-1){1'b0}}, auto_retry_r};
        end else if (BUS_RD && BUS_ADDR == ADDR_STATUS) begin
            BUS_RDATA <= {state_r, pg_r, dis_r, gate_r, flt_r};
        end else if (BUS_RD && BUS_ADDR == ADDR_CAUSE) begin
            BUS_RDATA <= cause_r;
        end else begin
            BUS_RDATA <= '0;
        end
    end

endmodule
`default_nettype wire

// ---- test/efs_supervisor_properties.sv ----
// Checker on the supervisor's outputs.
// Assumes bind into efs_supervisor; flags come from the bench.
`timescale 1ns/1ps
`default_nettype none
module efs_checker #(
    parameter int PGD_US = 1
) (
    // Clock, reset, flags
    input wire logic MCLK,
    input wire logic RST,
    input wire logic TEMP_HOT,
    input wire logic GATE_NEAR_VIN,
    // Outputs watched
    input wire logic GATE_DRIVE_ON,
    input wire logic OUTPUT_DISCHARGE,
    input wire logic SWITCH_ENABLE_LINE_OE,
    input wire logic FAULT_INDICATOR_N_O,
    input wire logic FAULT_INDICATOR_N_OE,
    input wire logic POWER_GOOD_OUT
);
    // ****
    // Properties
    // ****
    // Slack covers the flag synchroniser
    localparam int PGD_MAX = PGD_US * 25 + 6;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    a_line_tracks_gate: assert property (SWITCH_ENABLE_LINE_OE == !GATE_DRIVE_ON)
        else $error("enable line drive wrong");
    a_fault_pin_low: assert property (FAULT_INDICATOR_N_OE |-> !FAULT_INDICATOR_N_O)
        else $error("fault pin not pulled low");
    a_fault_gate_off: assert property (FAULT_INDICATOR_N_OE |-> !GATE_DRIVE_ON)
        else $error("gate on during fault");
    a_pg_after_gate: assert property ($rose(POWER_GOOD_OUT) |-> $past(GATE_DRIVE_ON, 24))
        else $error("power good too early");
    a_pg_drops: assert property ($fell(GATE_DRIVE_ON) && POWER_GOOD_OUT |-> ##[1:PGD_MAX] !POWER_GOOD_OUT)
        else $error("power good held");
    a_hot_no_discharge: assert property (TEMP_HOT [*7] |-> !OUTPUT_DISCHARGE)
        else $error("discharge while hot");
    a_discharge_gate_off: assert property (OUTPUT_DISCHARGE |-> !GATE_DRIVE_ON)
        else $error("discharge with gate on");
    a_gd_short_flag: assert property ((GATE_NEAR_VIN && !GATE_DRIVE_ON) [*8] |-> FAULT_INDICATOR_N_OE)
        else $error("gate-drain short missed");
endmodule
bind efs_supervisor efs_checker #(.PGD_US(PGD_US)) efs_checker_i (.MCLK(MCLK), .RST(RST), .TEMP_HOT(TEMP_HOT),
    .GATE_NEAR_VIN(GATE_NEAR_VIN), .GATE_DRIVE_ON(GATE_DRIVE_ON), .OUTPUT_DISCHARGE(OUTPUT_DISCHARGE),
    .SWITCH_ENABLE_LINE_OE(SWITCH_ENABLE_LINE_OE), .FAULT_INDICATOR_N_O(FAULT_INDICATOR_N_O),
    .FAULT_INDICATOR_N_OE(FAULT_INDICATOR_N_OE), .POWER_GOOD_OUT(POWER_GOOD_OUT));
`default_nettype wire

// ---- test/efs_host_model.sv ----
// Board side: pull-ups on open-drain pins, optional external pull on the enable line.
// Assumes the supervisor pulls low only through its output enables.
`timescale 1ns/1ps
`default_nettype none
module efs_host_model (
    // Fault indicator
    input  wire logic flt_level,
    input  wire logic flt_enable,
    output var  logic flt_pin,
    // Switch enable line
    input  wire logic en_level,
    input  wire logic en_enable,
    input  wire logic ext_pull,
    output var  logic en_line
);
    // Pull-up holds high unless someone sinks
    always_comb flt_pin = flt_enable ? flt_level : 1'b1;
    always_comb en_line = (en_enable ? en_level : 1'b1) & !ext_pull;
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Bench: flag stimulus, register port accesses, pin checks.
// Assumes shortened timers, 25 cycles per microsecond.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import efs_pkg::*;
    // ****
    // Signals and instances
    // ****
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [16:0] f = 17'h0081E;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic gate, disch, en_o, en_oe, flt_o, flt_oe, pg, flt_pin, en_line;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    logic [16:0] masks [8] = '{17'h00100, 17'h01100, 17'h00240, 17'h00080, 17'h00800, 17'h00003, 17'h00440,
        17'h10000};
    logic [7:0] causes [8] = '{8'h04, 8'h44, 8'h02, 8'h08, 8'h20, 8'h01, 8'h10, 8'h80};
    always #20 mclk = ~mclk;
    efs_supervisor #(.PGA_US(1), .PGD_US(1), .QOD_US(1), .SU_US(2), .SPF_US(2), .RST_US(4)) efs_supervisor_i (
        .MCLK(mclk), .RST(rst), .TEMP_HOT(f[0]), .TEMP_COOL(f[1]), .EN_ON(f[2]), .EN_ABOVE_SD(f[3]),
        .SUPPLY_OK(f[4]), .UV_OV(f[5]), .OC_PRIMARY(f[6]), .OC_BACKUP(f[7]), .FAST_TRIP(f[8]),
        .BLANK_EXPIRED(f[9]), .BLANK_STUCK(f[10]), .GATE_OVERDRIVE(f[11]), .GATE_NEAR_VIN(f[12]),
        .VDS_LOW(f[13]), .VOUT_BELOW_FB(f[14]), .GATE_DRIVE_ON(gate), .OUTPUT_DISCHARGE(disch),
        .SWITCH_ENABLE_LINE_I(en_line), .SWITCH_ENABLE_LINE_O(en_o), .SWITCH_ENABLE_LINE_OE(en_oe),
        .FAULT_INDICATOR_N_O(flt_o), .FAULT_INDICATOR_N_OE(flt_oe), .POWER_GOOD_OUT(pg), .BUS_ADDR(addr),
        .BUS_WDATA(wdata), .BUS_WR(wr), .BUS_RD(rd), .BUS_RDATA(rdata));
    efs_host_model efs_host_model_i (.flt_level(flt_o), .flt_enable(flt_oe), .flt_pin(flt_pin),
        .en_level(en_o), .en_enable(en_oe), .ext_pull(f[16]), .en_line(en_line));
    // ****
    // Tasks
    // ****
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic setf(input logic [16:0] v);
        @(posedge mclk);
        f <= v;
        #1;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge mclk);
        {addr, rd} <= {a, 1'b1};
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk(rdata, exp, what);
    endtask
    task automatic start_up;
        setf(17'h0081E);
        for (int i = 0; i < 20 && gate !== 1'b1; i++) cyc(1);
        chk(8'({gate, en_line}), 8'h03, "started");
        cyc(5);
        chk(8'(pg), 8'h00, "inrush pg");
        cyc(35);
        chk(8'(pg), 8'h01, "pg");
    endtask
    // Trip from steady state, hold, then clear by shutdown level or supply loss
    task automatic trip(input logic [16:0] m, input logic [7:0] cause, input logic [16:0] clr);
        start_up;
        setf(f ^ m);
        cyc(100);
        chk(8'({gate, pg, flt_pin, en_line}), 8'h00, "tripped");
        rd_reg(ADDR_CAUSE, cause, "cause");
        setf(f ^ m);
        setf(f & ~17'h00004);
        cyc(10);
        chk(8'(flt_pin), 8'h00, "held");
        setf(f & ~clr);
        cyc(10);
        chk(8'(flt_pin), 8'h01, "cleared");
        rd_reg(ADDR_CAUSE, 8'h00, "cause clear");
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Run takes some 1900 cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict;
        end
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        rd_reg(ADDR_CTRL, 8'h00, "ctrl");
        wr_reg(ADDR_CAUSE, 8'hFF);
        rd_reg(ADDR_CAUSE, 8'h00, "cause ro");
        rd_reg(4'hC, 8'h00, "unmapped");
        for (int i = 0; i < 8; i++) trip(masks[i], causes[i], i[0] ? 17'h00010 : 17'h00008);
        wr_reg(ADDR_CTRL, 8'h01);
        rd_reg(ADDR_CTRL, 8'h01, "ctrl");
        start_up;
        setf(f ^ 17'h00003);
        cyc(10);
        chk(8'({gate, flt_pin}), 8'h00, "hot");
        setf(f ^ 17'h00003);
        cyc(50);
        chk(8'(gate), 8'h00, "retry wait");
        for (int i = 0; i < 200 && gate !== 1'b1; i++) cyc(1);
        chk(8'(gate), 8'h01, "retried");
        setf(f ^ 17'h00100);
        cyc(10);
        rd_reg(ADDR_STATUS, 8'h71, "fast retry");
        setf(f ^ 17'h00100);
        for (int i = 0; i < 200 && gate !== 1'b1; i++) cyc(1);
        chk(8'(gate), 8'h01, "fast retried");
        wr_reg(ADDR_CTRL, 8'h00);
        setf(f | 17'h00020);
        cyc(10);
        chk(8'({gate, flt_pin}), 8'h01, "lockout");
        setf(17'h0081A);
        cyc(40);
        chk(8'(disch), 8'h01, "discharge");
        setf(f | 17'h04000);
        cyc(10);
        chk(8'(disch), 8'h00, "discharge end");
        setf(17'h0281E);
        cyc(15);
        chk(8'(disch), 8'h01, "ds discharge");
        cyc(60);
        rd_reg(ADDR_STATUS, 8'h21, "status");
        setf(17'h0081A);
        cyc(10);
        chk(8'(flt_pin), 8'h01, "ds release");
        give_verdict;
    end
endmodule
`default_nettype wire
